// File: apr_core.sv
// Phase delay, data-ready generation and offset/gain calibration of four channels.
//
// Behaviour
// [R1] The 24-bit delay word holds two 12-bit banks: low for pair 0/1, high for 2/3.
// [R2] Odd channel is the pair reference; positive bank delays even channel, negative advances.
// [R3] Even channel is shifted by the signed bank in modulator clock periods.
// [R4] Ready pulses of even and odd channel differ by the pair delay.
// [R5] Ready events sit half an oversampling ratio of modulator periods after restart.
// [R6] Usable delay spans minus half ratio to half ratio minus one.
// [R7] Any write of the delay word restarts all converters, even an equal value.
// [R8] Sign bit of each bank is bit 11 at ratio 4096, down to bit 4 at 32.
// [R9] With link mode 0 every enabled channel pulses the data-ready pin.
// [R10] With link mode 1, the default, only the most lagging active converter pulses.
// [R11] In linked mode all active channel outputs latch together on the lagging event.
// [R12] Status holds four read-only ready flags; writes to them do nothing.
// [R13] Flags reset to 1 and drop to 0 when their channel output updates.
// [R14] Any status read returns all four flags to 1.
// [R15] Linked mode updates all flags together; independent mode updates each separately.
// [R16] One offset enable and one gain enable act on all channels.
// [R17] Enabled offset adds the signed trim to the code with no added latency.
// [R18] Only offset bits inside current resolution are added, top 17 at ratio 32.
// [R19] No offset is added to a channel in reset or shutdown.
// [R20] No gain is applied to a channel in reset or shutdown.
// [R21] Trims are kept when enables clear and ignored while disabled.
// [R22] Corrected code is multiplied by one plus the gain trim times two to minus 23.
// [R23] Enabled gain delays ready events by 24 modulator periods from the next event.
// [R24] Out-of-range results saturate to the largest positive or most negative code.
// [R25] A channel update in the same cycle as a status read leaves the flag at 0.
`timescale 1ns/1ns
`include "apr_params.svh"

module apr_core
  import apr_pkg::*;
#(
  parameter int DM_DIV = `APR_DM_CYCLES
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  input  wire apr_reg_req_t       reg_req_i,
  input  wire logic [3:0]         ch_reset_i,
  input  wire logic [3:0]         ch_shdn_i,
  input  wire logic [3:0][23:0]   ch_raw_i,
  output logic      [23:0]        reg_rdata_o,
  output logic      [3:0][23:0]   ch_data_o,
  output logic                    data_ready_n_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [23:0]      cfg_r;
  logic [23:0]      phase_r;
  logic [3:0][23:0] off_r;
  logic [3:0][23:0] gain_r;
  logic [3:0]       flags_r;
  logic [3:0]       flags_nxt;
  logic [11:0]      pc_r;
  logic [15:0]      div_r;
  logic [23:0]      rdata_nxt;
  apr_cfg_t         cfg;

  assign cfg.osr               = cfg_r[`APR_CFG_OSR_LSB +: 3];
  assign cfg.ready_link_mode   = cfg_r[`APR_CFG_LINK_BIT];
  assign cfg.offset_cal_enable = cfg_r[`APR_CFG_OFFEN_BIT];
  assign cfg.gain_cal_enable   = cfg_r[`APR_CFG_GAINEN_BIT];
  assign cfg.width16           = cfg_r[`APR_CFG_W16_BIT];

  // ****************************************
  // Address decode
  // ****************************************
  wire        wr_phase  = reg_req_i.wr && (reg_req_i.addr == `APR_ADDR_PHASE);
  wire        wr_cfg    = reg_req_i.wr && (reg_req_i.addr == `APR_ADDR_CONFIG);
  wire        rd_status = reg_req_i.rd && (reg_req_i.addr == `APR_ADDR_STATUS);
  wire [3:0]  off_idx   = reg_req_i.addr - `APR_ADDR_OFFSET0;
  wire [3:0]  gain_idx  = reg_req_i.addr - `APR_ADDR_GAIN0;
  wire        wr_off    = reg_req_i.wr && (reg_req_i.addr >= `APR_ADDR_OFFSET0)
                          && (reg_req_i.addr < `APR_ADDR_GAIN0);
  wire        wr_gain   = reg_req_i.wr && (reg_req_i.addr >= `APR_ADDR_GAIN0)
                          && (off_idx < 4'h8);

  always_comb begin
    if (reg_req_i.addr == `APR_ADDR_STATUS) begin
      rdata_nxt = {20'h00000, flags_r}; // [R12]
    end else if (reg_req_i.addr == `APR_ADDR_CONFIG) begin
      rdata_nxt = cfg_r;
    end else if (reg_req_i.addr == `APR_ADDR_PHASE) begin
      rdata_nxt = phase_r;
    end else if (wr_off || (reg_req_i.addr >= `APR_ADDR_OFFSET0
                 && reg_req_i.addr < `APR_ADDR_GAIN0)) begin
      rdata_nxt = off_r[off_idx[1:0]];
    end else if (gain_idx < 4'h4) begin
      rdata_nxt = gain_r[gain_idx[1:0]];
    end else begin
      rdata_nxt = 24'h000000;
    end
  end

  // ****************************************
  // Modulator clock tick and frame counter
  // ****************************************
  wire        dm_tick  = (div_r == 16'(DM_DIV - 1)) && !wr_phase;
  wire [11:0] osr_mask = 12'(({12'h000, 1'b1} << (5 + cfg.osr)) - 1);
  wire [11:0] half     = 12'(({12'h000, 1'b1} << (4 + cfg.osr)));
  wire [11:0] gd       = cfg.gain_cal_enable ? 12'(`APR_GAIN_DELAY_DM) : 12'h000; // [R23]

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || wr_phase || dm_tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || wr_phase) begin
      pc_r <= 12'h000; // [R7]
    end else if (dm_tick) begin
      pc_r <= (pc_r + 12'h001) & osr_mask;
    end
  end

  // ****************************************
  // Per-pair delay and ready targets
  // ****************************************
  logic [1:0][12:0] dly;
  logic [3:0][11:0] tgt;
  logic [3:0]       act;
  logic signed [12:0] max_lag;
  logic               any_act;

  for (genvar p = 0; p < 2; p++) begin : g_pair
    wire [11:0] bank = phase_r[p*`APR_BANK_W +: `APR_BANK_W]; // [R1]
    wire [11:0] shl  = bank << (3'd7 - cfg.osr);
    // Sign bit moves down with the ratio; upper bits are dropped.
    assign dly[p] = 13'($signed({shl[11], shl}) >>> (3'd7 - cfg.osr)); // [R8] [R6]
    // Odd channel at the fixed reference, even shifted by the bank.
    assign tgt[2*p+1] = (half - 12'h001 + gd) & osr_mask; // [R5] [R2]
    assign tgt[2*p]   = (half - 12'h001 + dly[p][11:0] + gd) & osr_mask; // [R3] [R4]
  end

  assign act = ~ch_reset_i & ~ch_shdn_i;

  always_comb begin
    max_lag = -13'sd4096;
    any_act = 1'b0;
    for (int p = 0; p < 2; p++) begin
      if (act[2*p+1] && max_lag < 0) begin
        max_lag = 13'sd0;
      end
      if (act[2*p] && $signed(dly[p]) > max_lag) begin
        max_lag = $signed(dly[p]);
      end
      any_act = any_act | act[2*p] | act[2*p+1];
    end
  end

  wire [11:0] tgt_link = (half - 12'h001 + 12'(max_lag) + gd) & osr_mask;
  wire        ev_link  = dm_tick && any_act && (pc_r == tgt_link);
  logic [3:0] upd;

  for (genvar n = 0; n < 4; n++) begin : g_upd
    wire ev_own = dm_tick && (pc_r == tgt[n]);
    assign upd[n] = act[n] && (cfg.ready_link_mode ? ev_link : ev_own); // [R11] [R15]
  end

  // ****************************************
  // Calibration datapath
  // ****************************************
  logic [3:0][23:0] cal;

  for (genvar n = 0; n < 4; n++) begin : g_cal
    wire [23:0] off_mask = 24'hffffff << (3'd7 - cfg.osr); // [R18]
    wire        off_on   = cfg.offset_cal_enable && act[n]; // [R16] [R19] [R21]
    wire        gain_on  = cfg.gain_cal_enable && act[n]; // [R16] [R20] [R21]
    wire [23:0] off_use  = off_on ? (off_r[n] & off_mask) : 24'h000000;
    wire signed [24:0] pre = $signed({ch_raw_i[n][23], ch_raw_i[n]})
                             + $signed({off_use[23], off_use}); // [R17]
    wire signed [25:0] mul = gain_on ? 26'sh0800000 + $signed({{2{gain_r[n][23]}}, gain_r[n]})
                                     : 26'sh0800000; // [R22]
    wire signed [50:0] prod = pre * mul;
    wire signed [50:0] shr  = prod >>> 23;
    // Saturate to 24 bits; the 16-bit view of a clipped word is 7fff or 8000.
    assign cal[n] = (shr > 51'sh7fffff)  ? 24'h7fffff :
                    (shr < -51'sh800000) ? 24'h800000 : shr[23:0]; // [R24]
  end

  // ****************************************
  // Register writes, outputs and flags
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_r   <= `APR_CFG_RESET;
      phase_r <= `APR_PHASE_RESET;
      off_r   <= '0;
      gain_r  <= '0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= reg_req_i.wdata;
      end
      if (wr_phase) begin
        phase_r <= reg_req_i.wdata;
      end
      if (wr_off) begin
        off_r[off_idx[1:0]] <= reg_req_i.wdata;
      end
      if (wr_gain && gain_idx < 4'h4) begin
        gain_r[gain_idx[1:0]] <= reg_req_i.wdata;
      end
    end
  end

  always_comb begin
    flags_nxt = rd_status ? `APR_FLAGS_RESET : flags_r; // [R14]
    flags_nxt = flags_nxt & ~upd; // [R13] [R25]
  end

  logic [3:0][23:0] data_nxt;
  for (genvar n = 0; n < 4; n++) begin : g_out
    assign data_nxt[n] = upd[n] ? (cfg.width16 ? {8'h00, cal[n][23:8]} : cal[n])
                                : ch_data_o[n];
  end

  wire dr_fire = cfg.ready_link_mode ? ev_link : (|upd); // [R9] [R10]

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flags_r        <= `APR_FLAGS_RESET;
      ch_data_o      <= '0;
      data_ready_n_o <= 1'b1;
      reg_rdata_o    <= 24'h000000;
    end else begin
      flags_r        <= flags_nxt;
      ch_data_o      <= data_nxt;
      data_ready_n_o <= ~dr_fire;
      reg_rdata_o    <= rdata_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  flags_read_a: assert property (rd_status && upd == 4'h0 |=> flags_r == 4'hf) // [R14]
    else $error("status read did not set all flags");
  flag_update_a: assert property (upd[0] |=> !flags_r[0]) // [R13]
    else $error("channel 0 update did not clear its flag");
  read_vs_upd_a: assert property (rd_status && upd[2] |=> flags_r == ~($past(upd))) // [R25]
    else $error("update lost against status read");
  phase_restart_a: assert property (wr_phase |=> pc_r == 12'h000 && div_r == 16'h0000) // [R7]
    else $error("delay write did not restart");
  link_pin_a: assert property (cfg.ready_link_mode && dm_tick && !ev_link
                               |=> data_ready_n_o) // [R10]
    else $error("linked mode pulsed off the lagging event");
  indep_pin_a: assert property (!cfg.ready_link_mode && |upd |=> !data_ready_n_o) // [R9]
    else $error("independent update without pin pulse");
  odd_sync_a: assert property (act[1] && act[3] |-> upd[1] == upd[3]) // [R2]
    else $error("odd channels out of step");
  linked_latch_a: assert property (cfg.ready_link_mode && act == 4'hf && upd[0]
                                   |-> upd == 4'hf) // [R11]
    else $error("linked channels latched apart");
  no_cal_a: assert property (!cfg.offset_cal_enable && !cfg.gain_cal_enable
                             && !cfg.width16 && upd[1]
                             |=> ch_data_o[1] == $past(ch_raw_i[1])) // [R21]
    else $error("disabled calibration changed the code");

  ready_link_mode_c: cover property (cfg.ready_link_mode && ev_link ##1 !data_ready_n_o);
  dr_indep_c: cover property (!cfg.ready_link_mode && upd[0] && !upd[1]);
  rd_clash_c: cover property (rd_status && |upd);
  sat_c: cover property (upd[0] && cal[0] == 24'h7fffff);
  w16_c: cover property (upd[1] && cfg.width16);

  // ****************************************
  // Further checks
  // ****************************************
  dr_single_a: assert property ( // [R9]
    !data_ready_n_o
    |=> data_ready_n_o)
    else $error("data-ready pin low for more than one cycle");
  flags_write_a: assert property ( // [R12]
    reg_req_i.wr && reg_req_i.addr == `APR_ADDR_STATUS && !rd_status && upd == 4'h0
    |=> flags_r == $past(flags_r))
    else $error("write changed the ready flags");
  rdata_status_a: assert property ( // [R12]
    rd_status
    |=> reg_rdata_o == {20'h00000, $past(flags_r)})
    else $error("status read returned wrong flags");
  flag_update3_a: assert property ( // [R13]
    upd[3]
    |=> !flags_r[3])
    else $error("channel 3 update did not clear its flag");
  inactive_flag_a: assert property ( // [R13] [R19]
    !act[2] && !rd_status
    |=> flags_r[2] == $past(flags_r[2]))
    else $error("inactive channel changed its flag");
  inactive_hold_a: assert property ( // [R19] [R20]
    !act[2]
    |=> ch_data_o[2] == $past(ch_data_o[2]))
    else $error("inactive channel changed its output");
  pc_bound_a: assert property ( // [R5]
    dm_tick && !wr_cfg
    |=> (pc_r & ~osr_mask) == 12'h000)
    else $error("frame counter left its range");
  div_bound_a: assert property ( // [R3]
    div_r < 16'(DM_DIV))
    else $error("modulator divider out of range");
  odd_ref_a: assert property ( // [R5]
    !cfg.ready_link_mode && !cfg.gain_cal_enable && upd[1]
    |-> pc_r == half - 12'h001)
    else $error("odd channel off its reference point");
  gain_shift_a: assert property ( // [R23]
    cfg.ready_link_mode && cfg.gain_cal_enable && act == 4'hf
    && phase_r == 24'h000000 && ev_link
    |-> pc_r == ((half - 12'h001 + 12'(`APR_GAIN_DELAY_DM)) & osr_mask))
    else $error("gain delay not applied to ready event");
  no_link_idle_a: assert property ( // [R10]
    cfg.ready_link_mode && !any_act
    |=> data_ready_n_o)
    else $error("linked pulse with no active channel");
  off_hold_a: assert property ( // [R21]
    !wr_off
    |=> off_r == $past(off_r))
    else $error("offset trim changed without a write");
  gain_hold_a: assert property ( // [R21]
    !(wr_gain && gain_idx < 4'h4)
    |=> gain_r == $past(gain_r))
    else $error("gain trim changed without a write");
  w16_view_a: assert property ( // [R24]
    upd[1] && cfg.width16
    |=> ch_data_o[1][23:16] == 8'h00)
    else $error("16-bit output has upper bits set");
  sat_pos_a: assert property ( // [R24]
    upd[1] && !cfg.width16 && g_cal[1].shr > 51'sh7fffff
    |=> ch_data_o[1] == 24'h7fffff)
    else $error("positive overflow not clipped");
  sat_neg_a: assert property ( // [R24]
    upd[3] && !cfg.width16 && g_cal[3].shr < -51'sh800000
    |=> ch_data_o[3] == 24'h800000)
    else $error("negative overflow not clipped");

endmodule : apr_core

// File: apr_params.svh
// Constants of the phase, ready and calibration block.
`ifndef APR_PARAMS_SVH
`define APR_PARAMS_SVH

// ****************************************
// Register indices
// ****************************************
`define APR_ADDR_STATUS    4'h0
`define APR_ADDR_CONFIG    4'h1
`define APR_ADDR_PHASE     4'h2
`define APR_ADDR_OFFSET0   4'h3
`define APR_ADDR_GAIN0     4'h7

// ****************************************
// Config register fields
// ****************************************
`define APR_CFG_OSR_LSB    0
`define APR_CFG_LINK_BIT   3
`define APR_CFG_OFFEN_BIT  4
`define APR_CFG_GAINEN_BIT 5
`define APR_CFG_W16_BIT    6

// ****************************************
// Reset values
// ****************************************
`define APR_CFG_RESET      24'h00000b
`define APR_PHASE_RESET    24'h000000
`define APR_FLAGS_RESET    4'hf

// ****************************************
// Timing
// ****************************************
`define APR_REF_PERIOD_NS  10
`define APR_DM_PERIOD_NS   1000
`define APR_DM_CYCLES      (`APR_DM_PERIOD_NS / `APR_REF_PERIOD_NS)
`define APR_GAIN_DELAY_DM  24
`define APR_BANK_W         12
`define APR_MIN_RES        17

`endif

// File: apr_pkg.sv
// Types of the phase, ready and calibration block.
package apr_pkg;

  // ****************************************
  // Register access request
  // ****************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [23:0] wdata;
  } apr_reg_req_t;

  // ****************************************
  // Configuration fields
  // ****************************************
  typedef struct packed {
    logic [2:0] osr;
    logic       ready_link_mode;
    logic       offset_cal_enable;
    logic       gain_cal_enable;
    logic       width16;
  } apr_cfg_t;

endpackage : apr_pkg

// File: apr_host_model.sv
// Host model that counts data-ready pulses and stamps the cycle of the latest one.
`timescale 1ns/1ns

module apr_host_model (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic data_ready_n_i,
  output int        cyc_o,
  output int        last_at_o,
  output int        n_pulse_o
);
  // ****************************************
  // Pulse capture
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    cyc_o <= cyc_o + 1;
    if (!rst_n_i) begin
      n_pulse_o <= 0;
    end else if (data_ready_n_i === 1'b0) begin
      n_pulse_o <= n_pulse_o + 1;
      last_at_o <= cyc_o;
    end
  end
endmodule : apr_host_model

// File: test_adc_phase_ready_calibration.sv
// Self-checking bench of the phase, ready and calibration core.
`timescale 1ns/1ns
`include "apr_params.svh"
`define APR_CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module test_adc_phase_ready_calibration
  import apr_pkg::*;
;
  localparam int DIV = 4;
  localparam int OSR = 64;
  logic             ref_clk_i = 1'b0;
  logic             rst_n_i   = 1'b0;
  apr_reg_req_t     reg_req   = '0;
  logic [3:0]       ch_reset  = '0;
  logic [3:0]       ch_shdn   = '0;
  logic [3:0][23:0] ch_raw    = '0;
  logic [23:0]      rdata;
  logic [3:0][23:0] ch_data;
  logic             dr_n;
  logic [31:0]      seed      = 32'h8797017f;
  logic [23:0]      v;
  logic [23:0]      off0;
  int               cyc, last_at, n_pulse, t0, lat0, lat, d;
  int               n_fail     = 0;
  int               num_checks = 0;

  apr_core #(.DM_DIV(DIV)) apr_core_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_req_i(reg_req), .ch_reset_i(ch_reset), .ch_shdn_i(ch_shdn), .ch_raw_i(ch_raw),
    .reg_rdata_o(rdata), .ch_data_o(ch_data), .data_ready_n_o(dr_n));
  apr_host_model apr_host_model_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .data_ready_n_i(dr_n), .cyc_o(cyc), .last_at_o(last_at), .n_pulse_o(n_pulse));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [23:0] cal(logic [23:0] raw, logic [23:0] off, logic [23:0] g);
    longint s;
    s = $signed(raw) + $signed(off & 24'hffffc0);
    s = (s * (longint'(8388608) + $signed(g))) >>> 23;
    if (s > 8388607) return 24'h7fffff;
    if (s < -8388608) return 24'h800000;
    return s[23:0];
  endfunction : cal

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic wr(logic [3:0] a, logic [23:0] w);
    @(posedge ref_clk_i) reg_req <= '{1'b1, 1'b0, a, w};
    @(posedge ref_clk_i) reg_req <= '0;
    #1;
  endtask : wr

  task automatic rd(logic [3:0] a);
    @(posedge ref_clk_i) reg_req <= '{1'b0, 1'b1, a, 24'h0};
    @(posedge ref_clk_i) reg_req <= '0;
    #1 v = rdata;
  endtask : rd

  task automatic wait_dr();
    int k;
    k = n_pulse;
    for (int i = 0; i < 4000 && n_pulse == k; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (n_pulse == k) begin
      `APR_CHK("pulse", 1, 0)
      end_of_test();
    end
  endtask : wait_dr

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(`APR_ADDR_STATUS);
    `APR_CHK("flags reset", 24'h00000f, v)
    rd(`APR_ADDR_CONFIG);
    `APR_CHK("config reset", `APR_CFG_RESET, v)
    wr(`APR_ADDR_STATUS, 24'h0);
    rd(`APR_ADDR_STATUS);
    `APR_CHK("flags write", 24'h00000f, v)
    rd(4'hf);
    `APR_CHK("unmapped", 24'h0, v)
    $display("test reset done");
    wr(`APR_ADDR_CONFIG, 24'h000009);
    for (int n = 0; n < 2; n++) begin
      wr(`APR_ADDR_PHASE, 24'h0);
      t0 = cyc;
      wait_dr();
      lat = last_at - t0;
      if (n == 0) lat0 = lat;
      repeat (rnd() % 50) @(posedge ref_clk_i);
    end
    `APR_CHK("restart", lat0, lat)
    `APR_CHK("first event", 1'b1, lat0 >= (OSR/2-1)*DIV && lat0 <= OSR/2*DIV+6)
    d = 3 + rnd() % 29;
    for (int s = 0; s < 2; s++) begin
      wr(`APR_ADDR_PHASE, {12'h0, 6'(rnd()), 6'(s ? -d : d)});
      t0 = cyc;
      wait_dr();
      `APR_CHK("linked lag", lat0 + (s ? 0 : d*DIV), last_at - t0)
    end
    $display("test linked timing done");
    wr(`APR_ADDR_CONFIG, 24'h000001);
    wr(`APR_ADDR_PHASE, {12'h0, 6'(rnd()), 6'(d)});
    rd(`APR_ADDR_STATUS);
    wait_dr();
    t0 = last_at;
    rd(`APR_ADDR_STATUS);
    `APR_CHK("odd flags", 24'h000001, v)
    wait_dr();
    `APR_CHK("pair gap", d*DIV, last_at - t0)
    rd(`APR_ADDR_STATUS);
    `APR_CHK("even flags", 24'h00000e, v)
    $display("test independent done");
    off0 = rnd();
    @(posedge ref_clk_i) ch_shdn <= 4'b0100;
    ch_raw <= {24'ha00000, 24'(rnd()), 24'h600000, 24'(rnd() & 24'h0fffff)};
    for (int n = 0; n < 4; n++) begin
      wr(`APR_ADDR_OFFSET0 + 4'(n), n == 0 ? off0 : 24'h0);
      wr(`APR_ADDR_GAIN0 + 4'(n), n == 0 ? 24'h0 : 24'h7fffff);
    end
    wr(`APR_ADDR_CONFIG, 24'h000039);
    wr(`APR_ADDR_PHASE, 24'h0);
    wait_dr();
    rd(`APR_ADDR_STATUS);
    `APR_CHK("linked flags", 24'h000004, v)
    `APR_CHK("ch0 offset", cal(ch_raw[0], off0, 24'h0), ch_data[0])
    `APR_CHK("ch1 high", cal(ch_raw[1], 24'h0, 24'h7fffff), ch_data[1])
    `APR_CHK("ch2 off", 24'h0, ch_data[2])
    `APR_CHK("ch3 low", 24'h800000, ch_data[3])
    wr(`APR_ADDR_CONFIG, 24'h000029);
    wait_dr();
    `APR_CHK("offset ignored", cal(ch_raw[0], 24'h0, 24'h0), ch_data[0])
    rd(`APR_ADDR_OFFSET0);
    `APR_CHK("offset kept", off0, v)
    wr(`APR_ADDR_CONFIG, 24'h000069);
    wait_dr();
    `APR_CHK("ch1 high 16", 24'h007fff, ch_data[1])
    `APR_CHK("ch3 low 16", 24'h008000, ch_data[3])
    wr(`APR_ADDR_CONFIG, 24'h000009);
    wr(`APR_ADDR_PHASE, 24'h0);
    t0 = cyc;
    wait_dr();
    wr(`APR_ADDR_CONFIG, 24'h000029);
    wr(`APR_ADDR_PHASE, 24'h0);
    lat = last_at - t0;
    t0 = cyc;
    wait_dr();
    `APR_CHK("gain delay", lat + 24*DIV, last_at - t0)
    $display("test calibration done");
    end_of_test();
  end
endmodule : test_adc_phase_ready_calibration
